// ===== pkg/liu_ctrl_pkg.sv
// Register map, field layout and shared types of the line interface control bank
package liu_ctrl_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_GLOBAL_MGMT = 8'h07;
  localparam logic [7:0] OFF_ERROR_TESTER = 8'h10;
  localparam logic [7:0] OFF_VIOL_INSERT = 8'h11;
  localparam logic [7:0] OFF_LINE_VIOL = 8'h12;
  localparam logic [7:0] OFF_RX_CLK_INV = 8'h13;
  localparam logic [7:0] OFF_TX_CLK_INV = 8'h14;
  localparam logic [7:0] OFF_CLOCK_CTRL = 8'h15;
  localparam logic [7:0] OFF_STATUS_CTRL = 8'h1e;

  // ==========================================================================
  // Field positions and reset values
  localparam int HITLESS_BIT = 0;
  localparam int TESTER_SEL_LSB = 5;
  localparam int TESTER_EN_BIT = 0;
  localparam int PLL_SEL_LSB = 5;
  localparam int LINE_RATE_BIT = 4;
  localparam int AUX_SEL_LSB = 0;
  localparam int CLEAR_ON_WRITE_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int NUM_CHANNELS = 8;

  // ==========================================================================
  // Timing: capture window in line clock periods, one system cycle each
  localparam int VIOL_WINDOW_PERIODS = 3;
  localparam logic [1:0] VIOL_WINDOW_CYCLES = 2'(VIOL_WINDOW_PERIODS);

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    SEL_NONE, SEL_GLOBAL_MGMT, SEL_ERROR_TESTER, SEL_VIOL_INSERT, SEL_LINE_VIOL,
    SEL_RX_CLK_INV, SEL_TX_CLK_INV, SEL_CLOCK_CTRL, SEL_STATUS_CTRL
  } reg_sel_t;

  typedef enum logic {
    PLL_FROM_MASTER,
    PLL_FROM_CHANNEL
  } pll_src_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] bipolar;
    logic [7:0] code;
    logic [7:0] zero_run;
  } line_events_t;

  typedef struct packed {
    logic [7:0] zero_run_detect_enable;
    logic [7:0] code_violation_detect_disable;
    logic hdb3_mode;
    logic dual_rail_mode;
  } detect_cfg_t;

endpackage

// ===== verilog/violation_latch.sv
// One channel's sticky line-violation flag with its capture window
`timescale 1ns/1ns
`default_nettype none
module violation_latch
  import liu_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Qualified event and clear
  input wire logic event_in,
  input wire logic clear,
  // Sticky flag
  output logic flag_ff
);

  logic [1:0] window_ff;
  logic accept;

  // ==========================================================================
  // Window
  // Later events inside the window are dropped even after a clear
  assign accept = event_in && (window_ff == 2'h0);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      window_ff <= 2'h0;
    end else if (accept) begin
      window_ff <= VIOL_WINDOW_CYCLES - 2'h1;
    end else if (window_ff != 2'h0) begin
      window_ff <= window_ff - 2'h1;
    end
  end

  // ==========================================================================
  // Flag: set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else if (accept) begin
      flag_ff <= 1'b1;
    end else if (clear) begin
      flag_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/liu_diag_clock_ctrl_regs.sv
// Control and status register bank for diagnostics and clocking of an eight-channel LIU
//
// Contract
// - Hitless bit set and output-enable pin low turns off receiver impedance matching.
// - Tester select bits 7..5 pick the tester channel, only while enabled.
// - Tester enable bit 0 activates the tester on exactly one channel.
// - Rising edge of a violation-insert bit inserts one bipolar violation.
// - Bipolar, code or zero-run events latch the channel's line-violation bit.
// - Reading the line-violation status clears its latched bits.
// - Only the first violation in a three-period window is latched.
// - Zero-run events count only when zero-run detection is enabled.
// - Code violations count only in HDB3 mode and not when disabled.
// - In dual-rail mode only bipolar violations set status.
// - Receive invert bit selects falling-edge alignment of receive rails.
// - Clock-edge select pin high forces falling-edge receive alignment.
// - PLL select bits 7..5 choose the recovered clock feeding the PLL.
// - Loss of signal on the reference channel falls back to master clock.
// - PLL select applies only with PLL input select one, else master clock.
// - Line-rate select bit picks 2.048 MHz when set, 1.544 MHz clear.
// - With clear-on-write enabled, status clears by writing one, not reading.
`timescale 1ns/1ns
`default_nettype none
module liu_diag_clock_ctrl_regs
  import liu_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata_ff,
  // Device pins
  input wire logic output_enable_pin,
  input wire logic clock_edge_select_pin,
  // Receive side status, same clock
  input wire line_events_t line_events,
  input wire logic [7:0] loss_of_signal,
  // Configuration held by neighbouring register banks
  input wire detect_cfg_t detect_cfg,
  input wire logic pll_input_select,
  // Receiver and transmitter control
  output logic hitless_rx_term_off_ff,
  output logic [7:0] rx_falling_edge_ff,
  output logic [7:0] tx_clock_invert_bit_ff,
  // Tester and violation insertion
  output logic [7:0] tester_channel_onehot_ff,
  output logic [7:0] violation_insert_pulse_ff,
  // Clock control
  output pll_src_t pll_src_ff,
  output logic [2:0] pll_ref_channel_ff,
  output logic line_rate_clock_sel_ff,
  output logic [3:0] aux_clock_freq_sel_ff
);

  // ==========================================================================
  // Decode
  function automatic reg_sel_t decode(input logic [7:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    unique case (addr)
      OFF_GLOBAL_MGMT: sel = SEL_GLOBAL_MGMT;
      OFF_ERROR_TESTER: sel = SEL_ERROR_TESTER;
      OFF_VIOL_INSERT: sel = SEL_VIOL_INSERT;
      OFF_LINE_VIOL: sel = SEL_LINE_VIOL;
      OFF_RX_CLK_INV: sel = SEL_RX_CLK_INV;
      OFF_TX_CLK_INV: sel = SEL_TX_CLK_INV;
      OFF_CLOCK_CTRL: sel = SEL_CLOCK_CTRL;
      OFF_STATUS_CTRL: sel = SEL_STATUS_CTRL;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  reg_sel_t req_sel;
  logic wr_hit_global;
  logic wr_hit_tester;
  logic wr_hit_insert;
  logic wr_hit_line_viol;
  logic wr_hit_rx_inv;
  logic wr_hit_tx_inv;
  logic wr_hit_clock;
  logic wr_hit_status;
  logic rd_hit_line_viol;

  assign req_sel = decode(reg_req.addr);
  assign wr_hit_global = reg_req.wr && (req_sel == SEL_GLOBAL_MGMT);
  assign wr_hit_tester = reg_req.wr && (req_sel == SEL_ERROR_TESTER);
  assign wr_hit_insert = reg_req.wr && (req_sel == SEL_VIOL_INSERT);
  assign wr_hit_line_viol = reg_req.wr && (req_sel == SEL_LINE_VIOL);
  assign wr_hit_rx_inv = reg_req.wr && (req_sel == SEL_RX_CLK_INV);
  assign wr_hit_tx_inv = reg_req.wr && (req_sel == SEL_TX_CLK_INV);
  assign wr_hit_clock = reg_req.wr && (req_sel == SEL_CLOCK_CTRL);
  assign wr_hit_status = reg_req.wr && (req_sel == SEL_STATUS_CTRL);
  assign rd_hit_line_viol = reg_req.rd && (req_sel == SEL_LINE_VIOL);

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] oe_sync_ff;
  logic [1:0] edge_sel_sync_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      oe_sync_ff <= 2'b11;
      edge_sel_sync_ff <= 2'b00;
    end else begin
      oe_sync_ff <= {oe_sync_ff[0], output_enable_pin};
      edge_sel_sync_ff <= {edge_sel_sync_ff[0], clock_edge_select_pin};
    end
  end

  // ==========================================================================
  // Writable registers
  logic [7:0] global_mgmt_reg_ff;
  logic [7:0] error_tester_ctrl_ff;
  logic [7:0] violation_insert_ctrl_ff;
  logic [7:0] rx_clock_invert_ff;
  logic [7:0] tx_clock_invert_ff;
  logic [7:0] clock_ctrl_reg_ff;
  logic [7:0] status_ctrl_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      global_mgmt_reg_ff <= REG_RESET;
    end else if (wr_hit_global) begin
      global_mgmt_reg_ff <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      error_tester_ctrl_ff <= REG_RESET;
    end else if (wr_hit_tester) begin
      error_tester_ctrl_ff <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      violation_insert_ctrl_ff <= REG_RESET;
    end else if (wr_hit_insert) begin
      violation_insert_ctrl_ff <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_clock_invert_ff <= REG_RESET;
    end else if (wr_hit_rx_inv) begin
      rx_clock_invert_ff <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_clock_invert_ff <= REG_RESET;
    end else if (wr_hit_tx_inv) begin
      tx_clock_invert_ff <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clock_ctrl_reg_ff <= REG_RESET;
    end else if (wr_hit_clock) begin
      clock_ctrl_reg_ff <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_ctrl_ff <= REG_RESET;
    end else if (wr_hit_status) begin
      status_ctrl_ff <= reg_req.wdata;
    end
  end

  // ==========================================================================
  // Hitless protection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hitless_rx_term_off_ff <= 1'b0;
    end else begin
      hitless_rx_term_off_ff <= global_mgmt_reg_ff[HITLESS_BIT] && !oe_sync_ff[1];
    end
  end

  // ==========================================================================
  // Error tester attachment
  logic [2:0] tester_sel;
  logic tester_en;

  assign tester_sel = error_tester_ctrl_ff[TESTER_SEL_LSB +: 3];
  assign tester_en = error_tester_ctrl_ff[TESTER_EN_BIT];

  // One-hot guarantees a single channel; code n drives bit n, channel n+1
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tester_channel_onehot_ff <= 8'h00;
    end else if (tester_en) begin
      tester_channel_onehot_ff <= 8'h01 << tester_sel;
    end else begin
      tester_channel_onehot_ff <= 8'h00;
    end
  end

  // ==========================================================================
  // Violation insertion
  // Only a rising edge fires; a bit held high inserts nothing more
  logic [7:0] insert_prev_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      insert_prev_ff <= 8'h00;
    end else begin
      insert_prev_ff <= violation_insert_ctrl_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      violation_insert_pulse_ff <= 8'h00;
    end else begin
      violation_insert_pulse_ff <= violation_insert_ctrl_ff & ~insert_prev_ff;
    end
  end

  // ==========================================================================
  // Line violation status
  logic [7:0] qualified_event;
  logic [7:0] status_clear;
  logic [7:0] line_violation_status;
  logic clear_on_write_enable;

  assign clear_on_write_enable = status_ctrl_ff[CLEAR_ON_WRITE_BIT];

  // Dual rail leaves only bipolar violations relevant
  assign qualified_event = line_events.bipolar
    | (line_events.code & ~detect_cfg.code_violation_detect_disable
       & {8{detect_cfg.hdb3_mode && !detect_cfg.dual_rail_mode}})
    | (line_events.zero_run & detect_cfg.zero_run_detect_enable
       & {8{!detect_cfg.dual_rail_mode}});

  always_comb begin
    if (clear_on_write_enable) begin
      status_clear = wr_hit_line_viol ? reg_req.wdata : 8'h00;
    end else begin
      status_clear = rd_hit_line_viol ? 8'hff : 8'h00;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch = ch + 1) begin : g_viol
      violation_latch u_latch (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .event_in(qualified_event[ch]),
        .clear(status_clear[ch]),
        .flag_ff(line_violation_status[ch])
      );
    end
  endgenerate

  // ==========================================================================
  // Receive and transmit clock edges
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_falling_edge_ff <= 8'h00;
    end else begin
      rx_falling_edge_ff <= rx_clock_invert_ff | {8{edge_sel_sync_ff[1]}};
    end
  end

  // Device only reports the expected edge; the framer keeps alignment
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_clock_invert_bit_ff <= 8'h00;
    end else begin
      tx_clock_invert_bit_ff <= tx_clock_invert_ff;
    end
  end

  // ==========================================================================
  // PLL reference selection
  logic [2:0] pll_sel;
  pll_src_t nxt_pll_src;

  assign pll_sel = clock_ctrl_reg_ff[PLL_SEL_LSB +: 3];

  // Fallback tracks loss of signal each cycle, so recovery is automatic
  always_comb begin
    if (pll_input_select && !loss_of_signal[pll_sel]) begin
      nxt_pll_src = PLL_FROM_CHANNEL;
    end else begin
      nxt_pll_src = PLL_FROM_MASTER;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pll_src_ff <= PLL_FROM_MASTER;
      pll_ref_channel_ff <= 3'h0;
    end else begin
      pll_src_ff <= nxt_pll_src;
      pll_ref_channel_ff <= pll_sel;
    end
  end

  // ==========================================================================
  // Output clock rates
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      line_rate_clock_sel_ff <= 1'b0;
      aux_clock_freq_sel_ff <= 4'h0;
    end else begin
      line_rate_clock_sel_ff <= clock_ctrl_reg_ff[LINE_RATE_BIT];
      aux_clock_freq_sel_ff <= clock_ctrl_reg_ff[AUX_SEL_LSB +: 4];
    end
  end

  // ==========================================================================
  // Read data
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = READ_UNMAPPED;
    unique case (req_sel)
      SEL_GLOBAL_MGMT: nxt_rdata = global_mgmt_reg_ff;
      SEL_ERROR_TESTER: nxt_rdata = error_tester_ctrl_ff;
      SEL_VIOL_INSERT: nxt_rdata = violation_insert_ctrl_ff;
      SEL_LINE_VIOL: nxt_rdata = line_violation_status;
      SEL_RX_CLK_INV: nxt_rdata = rx_clock_invert_ff;
      SEL_TX_CLK_INV: nxt_rdata = tx_clock_invert_ff;
      SEL_CLOCK_CTRL: nxt_rdata = clock_ctrl_reg_ff;
      SEL_STATUS_CTRL: nxt_rdata = status_ctrl_ff;
      SEL_NONE: nxt_rdata = READ_UNMAPPED;
    endcase
  end

  // Data holds until the next read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule
`default_nettype wire

// ===== tb/liu_diag_monitor.sv
// Port-level assertions for the line interface control bank
`timescale 1ns/1ns
`default_nettype none
module liu_diag_monitor
  import liu_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Inputs
  input wire reg_req_t reg_req,
  input wire logic output_enable_pin,
  input wire logic clock_edge_select_pin,
  input wire logic [7:0] loss_of_signal,
  input wire logic pll_input_select,
  // Outputs
  input wire logic hitless_rx_term_off_ff,
  input wire logic [7:0] rx_falling_edge_ff,
  input wire logic [7:0] tester_channel_onehot_ff,
  input wire logic [7:0] violation_insert_pulse_ff,
  input wire pll_src_t pll_src_ff,
  input wire logic [2:0] pll_ref_channel_ff
);
  // ==========================================================================
  // Sequences
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic ins_wr = reg_req.wr && reg_req.addr == OFF_VIOL_INSERT;
  // Pins pass a two-flop sync, so a level must persist before it counts
  sequence s_pin_held(logic pin);
    pin [*4];
  endsequence
  sequence s_ref_steady(logic lost);
    ($stable(pll_ref_channel_ff) && pll_input_select
      && loss_of_signal[pll_ref_channel_ff] == lost) [*3];
  endsequence
  // ==========================================================================
  // Assertions
  chk_insert_single: assert property (
    !(|(violation_insert_pulse_ff & $past(violation_insert_pulse_ff))))
    else $error("insert pulse longer than one cycle");
  chk_insert_cause: assert property (
    $rose(|violation_insert_pulse_ff) |-> $past(ins_wr, 2))
    else $error("insert pulse without insert write");
  chk_tester_onehot: assert property ($onehot0(tester_channel_onehot_ff))
    else $error("tester on more than one channel");
  chk_pll_master_sel: assert property (
    !pll_input_select |=> pll_src_ff == PLL_FROM_MASTER)
    else $error("pll not on master clock");
  // Select must also hold one more cycle, as the copy lags the live field
  chk_pll_los_fallback: assert property (
    s_ref_steady(1'b1) ##1 $stable(pll_ref_channel_ff) |-> pll_src_ff == PLL_FROM_MASTER)
    else $error("pll kept lost reference");
  chk_pll_channel_sel: assert property (
    s_ref_steady(1'b0) ##1 $stable(pll_ref_channel_ff) |-> pll_src_ff == PLL_FROM_CHANNEL)
    else $error("pll not on recovered clock");
  chk_rx_edge_pin: assert property (
    s_pin_held(clock_edge_select_pin) |=> rx_falling_edge_ff == 8'hff)
    else $error("edge pin not forcing falling edge");
  chk_hitless_oe_high: assert property (
    s_pin_held(output_enable_pin) |=> !hitless_rx_term_off_ff)
    else $error("termination off while outputs enabled");
endmodule
bind liu_diag_clock_ctrl_regs liu_diag_monitor u_mon (.sys_clk, .rst_n, .reg_req,
  .output_enable_pin, .clock_edge_select_pin, .loss_of_signal, .pll_input_select,
  .hitless_rx_term_off_ff, .rx_falling_edge_ff, .tester_channel_onehot_ff,
  .violation_insert_pulse_ff, .pll_src_ff, .pll_ref_channel_ff);
`default_nettype wire

// ===== tb/line_side_model.sv
// Framer-side model: line event pulses and transmit launch edge
`timescale 1ns/1ns
`default_nettype none
module line_side_model
  import liu_ctrl_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Framer side
  input wire logic [7:0] tx_invert,
  output var line_events_t events,
  output logic [7:0] tx_rising_launch
);
  // ==========================================================================
  // Behaviour
  assign tx_rising_launch = tx_invert;
  initial events = '0;
  // Second event after gap cycles probes the capture window
  task automatic pulse(input int kind, input int ch, input int gap);
    line_events_t e;
    for (int i = 0; i <= gap; i++) begin
      e = '0;
      if (i == 0 || i == gap) begin
        e.bipolar[ch] = (kind == 0);
        e.code[ch] = (kind == 1);
        e.zero_run[ch] = (kind == 2);
      end
      @(posedge sys_clk);
      events <= e;
    end
    @(posedge sys_clk);
    events <= '0;
  endtask
endmodule
`default_nettype wire

// ===== tb/test_liu_diag_clock_ctrl_regs.sv
// Self-checking bench for the line interface control bank
`timescale 1ns/1ns
`default_nettype none
module test_liu_diag_clock_ctrl_regs
  import liu_ctrl_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t reg_req = '0;
  logic oe_pin = 1'b1;
  logic edge_pin = 1'b0;
  logic [7:0] los = 8'h00;
  detect_cfg_t cfg = '0;
  logic pll_sel = 1'b0;
  line_events_t events;
  logic [7:0] rdata, rx_fall, tx_inv, tx_rise, tester, ins;
  logic hitless, rate;
  logic [2:0] pll_ref;
  logic [3:0] aux;
  pll_src_t pll_src;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] amap [9] = '{OFF_GLOBAL_MGMT, OFF_ERROR_TESTER, OFF_RX_CLK_INV, OFF_TX_CLK_INV,
    OFF_CLOCK_CTRL, OFF_STATUS_CTRL, OFF_VIOL_INSERT, OFF_LINE_VIOL, 8'h20};
  logic [7:0] wv [5] = '{8'h01, 8'ha1, 8'h5a, 8'hc3, 8'hb7};
  always #5 sys_clk = ~sys_clk;

  liu_diag_clock_ctrl_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata_ff(rdata), .output_enable_pin(oe_pin), .clock_edge_select_pin(edge_pin),
    .line_events(events), .loss_of_signal(los), .detect_cfg(cfg), .pll_input_select(pll_sel),
    .hitless_rx_term_off_ff(hitless), .rx_falling_edge_ff(rx_fall),
    .tx_clock_invert_bit_ff(tx_inv), .tester_channel_onehot_ff(tester),
    .violation_insert_pulse_ff(ins), .pll_src_ff(pll_src), .pll_ref_channel_ff(pll_ref),
    .line_rate_clock_sel_ff(rate), .aux_clock_freq_sel_ff(aux));
  line_side_model u_line (.sys_clk(sys_clk), .tx_invert(tx_inv), .events(events),
    .tx_rising_launch(tx_rise));

  // ==========================================================================
  // Tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 check(rdata, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic ins_chk(input logic [7:0] d, input logic [7:0] exp_cnt);
    int n = 0;
    wr(OFF_VIOL_INSERT, d);
    repeat (5) begin
      @(posedge sys_clk);
      #1 if (ins === 8'h04) n++;
    end
    check(8'(n), exp_cnt);
  endtask
  task automatic viol(input int kind, input int ch, input detect_cfg_t c, input logic [7:0] exp);
    @(posedge sys_clk);
    cfg <= c;
    u_line.pulse(kind, ch, 0);
    rd_chk(OFF_LINE_VIOL, exp);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (amap[i]) rd_chk(amap[i], REG_RESET);
    check(tester | ins | rx_fall | tx_inv, 8'h00);
    $display("test reset done");
    foreach (wv[i]) wr(amap[i], wv[i]);
    wr(8'h20, 8'hff);
    foreach (wv[i]) rd_chk(amap[i], wv[i]);
    rd_chk(8'h20, READ_UNMAPPED);
    settle(1);
    check(tester, 8'h20);
    check(rx_fall, 8'h5a);
    check(tx_rise, 8'hc3);
    check({5'h00, pll_ref}, 8'h05);
    check({3'h0, rate, aux}, 8'h17);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_ERROR_TESTER, {3'(i), 5'h01});
      settle(1);
      check(tester, 8'h01 << i);
    end
    wr(OFF_ERROR_TESTER, 8'he0);
    settle(1);
    check(tester, 8'h00);
    $display("test registers done");
    @(posedge sys_clk);
    edge_pin <= 1'b1;
    settle(5);
    check(rx_fall, 8'hff);
    @(posedge sys_clk);
    oe_pin <= 1'b0;
    edge_pin <= 1'b0;
    settle(5);
    check({7'h00, hitless}, 8'h01);
    check(rx_fall, 8'h5a);
    @(posedge sys_clk);
    oe_pin <= 1'b1;
    pll_sel <= 1'b1;
    settle(5);
    check({7'h00, hitless}, 8'h00);
    check({7'h00, pll_src}, {7'h00, PLL_FROM_CHANNEL});
    @(posedge sys_clk);
    los <= 8'h20;
    settle(4);
    check({7'h00, pll_src}, {7'h00, PLL_FROM_MASTER});
    @(posedge sys_clk);
    los <= 8'h10;
    settle(4);
    check({7'h00, pll_src}, {7'h00, PLL_FROM_CHANNEL});
    @(posedge sys_clk);
    pll_sel <= 1'b0;
    settle(4);
    check({7'h00, pll_src}, {7'h00, PLL_FROM_MASTER});
    $display("test pins and pll done");
    ins_chk(8'h04, 8'h01);
    ins_chk(8'h04, 8'h00);
    ins_chk(8'h00, 8'h00);
    ins_chk(8'h04, 8'h01);
    $display("test insertion done");
    viol(0, 0, {16'h0000, 2'b10}, 8'h01);
    rd_chk(OFF_LINE_VIOL, 8'h00);
    viol(2, 2, {16'h0000, 2'b10}, 8'h00);
    viol(2, 2, {16'h0400, 2'b10}, 8'h04);
    viol(1, 3, {16'h0000, 2'b10}, 8'h08);
    viol(1, 3, {16'h0008, 2'b10}, 8'h00);
    viol(1, 3, {16'h0000, 2'b00}, 8'h00);
    viol(1, 4, {16'h0000, 2'b11}, 8'h00);
    viol(2, 4, {16'h1000, 2'b01}, 8'h00);
    viol(0, 4, {16'h0000, 2'b01}, 8'h10);
    for (int g = 2; g < 4; g++) begin
      fork
        u_line.pulse(0, 1, g);
        begin
          @(posedge sys_clk);
          rd_chk(OFF_LINE_VIOL, 8'h02);
        end
      join
      rd_chk(OFF_LINE_VIOL, (g == 3) ? 8'h02 : 8'h00);
    end
    wr(OFF_STATUS_CTRL, 8'h01);
    viol(0, 3, {16'h0000, 2'b10}, 8'h08);
    rd_chk(OFF_LINE_VIOL, 8'h08);
    wr(OFF_LINE_VIOL, 8'h08);
    rd_chk(OFF_LINE_VIOL, 8'h00);
    $display("test line violations done");
    final_report();
  end
endmodule
`default_nettype wire
